// *** common/dscr_pkg.sv ***
// Constants and types shared by the dual synthesizer control block
package dscr_pkg;
   // Access lengths in serial clock cycles
   localparam int unsigned CTRL_BITS = 8;
   localparam int unsigned REF_BITS = 16;
   localparam int unsigned LOOP_BITS = 24;
   localparam int unsigned SHIFT_W = 24;
   localparam logic [4:0] CNT_CTRL = 5'h08;
   localparam logic [4:0] CNT_REF = 5'h10;
   localparam logic [4:0] CNT_LOOP = 5'h18;
   localparam logic [4:0] CNT_MAX = 5'h1F;
   // Control byte fields
   localparam int unsigned C_STEER = 7;
   localparam int unsigned C_STBY = 6;
   localparam int unsigned C_I2 = 5;
   localparam int unsigned C_I1 = 4;
   localparam int unsigned C_TYPE = 2;
   localparam int unsigned C_PORT = 1;
   localparam int unsigned C_POL = 0;
   // Control reset: both current bits high, type, polarity low, port released
   localparam logic [7:0] CTRL_RST = 8'h32;
   // Reference register fields
   localparam int unsigned R_MODE_LSB = 13;
   localparam int unsigned RATIO_W = 13;
   localparam int unsigned LOOP_W = 24;
   // Mode code giving input divided by eight (arbitrary encoding)
   localparam logic [2:0] MODE_DIV8 = 3'h4;
   localparam logic [2:0] MODE_STATIC_LOW = 3'h0;
   localparam logic [12:0] RATIO_RST = 13'h0001;
   typedef enum logic [1:0] {DSCR_RUN, DSCR_STBY, DSCR_ARM} dscr_loop_state_t;
endpackage : dscr_pkg

// *** logic/dscr_serial_rx.sv ***
// Serial receiver: shifts bits, counts clocks, commits at end of access
`timescale 1ns/1ps
module dscr_serial_rx (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic sclk_i,
   input wire logic sdin_i,
   input wire logic enb_n_i,
   output logic done_o,
   output logic [4:0] count_o,
   output logic [dscr_pkg::SHIFT_W-1:0] data_o
);
   import dscr_pkg::*;
   typedef struct packed {
      logic [2:0] sclk_s;
      logic [1:0] sd_s;
      logic [1:0] en_s;
      logic en_d;
      logic [4:0] cnt;
      logic [SHIFT_W-1:0] sh;
      logic done;
      logic [4:0] cnt_out;
      logic [SHIFT_W-1:0] dat_out;
   } dscr_rx_t;
   dscr_rx_t st_r, st_nxt;
   // Pins pass two flops; edges read only the synchronised stages
   always_comb begin
      st_nxt = st_r;
      st_nxt.sclk_s = {st_r.sclk_s[1:0], sclk_i};
      st_nxt.sd_s = {st_r.sd_s[0], sdin_i};
      st_nxt.en_s = {st_r.en_s[0], enb_n_i};
      st_nxt.en_d = st_r.en_s[1];
      st_nxt.done = 1'b0;
      if (st_r.en_s[1]) begin
         st_nxt.cnt = '0;
      end else if (st_r.sclk_s[1] && !st_r.sclk_s[2]) begin
         st_nxt.sh = {st_r.sh[SHIFT_W-2:0], st_r.sd_s[1]};
         if (st_r.cnt != CNT_MAX) st_nxt.cnt = st_r.cnt + 5'h01;
      end
      // Commit only on rising enable, never mid transfer
      if (st_r.en_s[1] && !st_r.en_d) begin
         st_nxt.done = 1'b1;
         st_nxt.cnt_out = st_r.cnt;
         st_nxt.dat_out = st_r.sh;
      end
   end
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= '{sclk_s: '0, sd_s: '0, en_s: 2'h3, en_d: 1'b1, cnt: '0, sh: '0,
                   done: 1'b0, cnt_out: '0, dat_out: '0};
      end else begin
         st_r <= st_nxt;
      end
   end
   assign done_o = st_r.done;
   assign count_o = st_r.cnt_out;
   assign data_o = st_r.dat_out;
endmodule : dscr_serial_rx

// *** logic/dscr_loop_seq.sv ***
// Per loop standby sequencer and reference counter ratio swap
`timescale 1ns/1ps
module dscr_loop_seq (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic stby_i,
   input wire logic ref_pulse_i,
   input wire logic load_rs_i,
   input wire logic [dscr_pkg::RATIO_W-1:0] ratio_buf_i,
   output logic counters_en_o,
   output logic jam_load_o,
   output logic det_en_o,
   output logic [dscr_pkg::RATIO_W-1:0] ratio_act_o
);
   import dscr_pkg::*;
   typedef struct packed {
      dscr_loop_state_t fsm;
      logic jam;
      logic pend;
      logic [RATIO_W-1:0] rs;
      logic [RATIO_W-1:0] act;
   } dscr_seq_t;
   dscr_seq_t st_r, st_nxt;
   // Standby entry, two step exit, ratio swap at cycle end
   always_comb begin
      st_nxt = st_r;
      st_nxt.jam = 1'b0;
      case (st_r.fsm)
         DSCR_RUN: if (stby_i) st_nxt.fsm = DSCR_STBY;
         DSCR_STBY: if (!stby_i) st_nxt.fsm = DSCR_ARM;
         DSCR_ARM: begin
            if (stby_i) begin
               st_nxt.fsm = DSCR_STBY;
            end else if (ref_pulse_i) begin
               st_nxt.fsm = DSCR_RUN;
               st_nxt.jam = 1'b1;
            end
         end
         default: st_nxt.fsm = DSCR_STBY;
      endcase
      if (load_rs_i) begin
         st_nxt.rs = ratio_buf_i;
         st_nxt.pend = 1'b1;
      end
      // New ratio only after the present count ends
      if (st_r.pend && ref_pulse_i && !load_rs_i) begin
         st_nxt.act = st_r.rs;
         st_nxt.pend = 1'b0;
      end
   end
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= '{fsm: DSCR_RUN, jam: 1'b0, pend: 1'b0, rs: RATIO_RST, act: RATIO_RST};
      end else begin
         st_r <= st_nxt;
      end
   end
   assign counters_en_o = (st_r.fsm != DSCR_STBY);
   assign det_en_o = (st_r.fsm == DSCR_RUN);
   assign jam_load_o = st_r.jam;
   assign ratio_act_o = st_r.act;
   a_arm_no_det: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (st_r.fsm == DSCR_ARM) |-> !det_en_o && counters_en_o) else $error("detector on early");
   a_jam_on_pulse: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (st_r.fsm == DSCR_ARM && !stby_i && ref_pulse_i) |=> jam_load_o && det_en_o)
      else $error("jam load missed");
   a_stby_stops: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      stby_i |=> !counters_en_o) else $error("counters run in standby");
   a_ratio_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !ref_pulse_i |=> $stable(ratio_act_o)) else $error("ratio changed mid count");
endmodule : dscr_loop_seq

// *** logic/dscr_ctrl_regs.sv ***
// Dual synthesizer control registers: serial decode, standby, outputs
//
// Behaviour
// - Control byte top bit low steers to main, high to second register.
// - Main standby idles both loops; second standby idles second loop only.
// - Standby floats charge output, stops counters, current and prescaler.
// - Standby forces double-ended outputs high and lock detect low.
// - Standby keeps every register and still accepts serial writes.
// - Static-low reference with main standby disconnects feedback, inhibits input.
// - Second-loop standby leaves the reference oscillator untouched.
// - Exit step one enables counters and, for source/sink type only, current; detectors still blocked.
// - Next reference pulse jam loads counters, then detectors receive pulses.
// - Two current level bits; both high is maximum; reset sets both.
// - Detector type high double-ended, low source/sink; reset clears it.
// - Main port bit drives port output; high releases, low pulls low.
// - Polarity bit inverts source/sink sense and swaps double outputs.
// - Eight clocks write only the steered control register.
// - Sixteen clocks: top three mode bits, low thirteen divide ratio.
// - After reset reference output is input divided by eight.
// - Reference write applies mode now, ratio to first buffer only.
// - Later loop write copies buffered ratio; swap at count end.
// - Twenty-four clocks write a loop divide register.
`timescale 1ns/1ps
module dscr_ctrl_regs (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic sclk_i,
   input wire logic sdin_i,
   input wire logic enb_n_i,
   input wire logic ref_pulse_main_i,
   input wire logic ref_pulse_sec_i,
   input wire logic fb_pulse_main_i,
   input wire logic fb_pulse_sec_i,
   input wire logic port_select_i,
   output logic [1:0] stby_o,
   output logic [1:0] counters_en_o,
   output logic [1:0] jam_load_o,
   output logic [1:0] rset_current_en_o,
   output logic [1:0] prescaler_low_power_o,
   output logic [1:0] charge_float_o,
   output logic [1:0] charge_source_o,
   output logic [1:0] charge_sink_o,
   output logic [3:0] current_level_o,
   output logic [1:0] detector_type_select_o,
   output logic [1:0] detector_invert_bit_o,
   output logic [1:0] phase_ref_n_o,
   output logic [1:0] phase_fb_n_o,
   output logic [1:0] lock_detect_output_o,
   output logic [1:0] lock_detect_oe_o,
   output logic port_out_o,
   output logic port_oe_o,
   output logic [2:0] ref_osc_mode_o,
   output logic osc_feedback_off_o,
   output logic reference_input_inhibit_o,
   output logic [dscr_pkg::RATIO_W-1:0] ratio_buf_o,
   output logic [dscr_pkg::RATIO_W-1:0] ratio_main_o,
   output logic [dscr_pkg::RATIO_W-1:0] ratio_sec_o,
   output logic [dscr_pkg::LOOP_W-1:0] loop_main_o,
   output logic [dscr_pkg::LOOP_W-1:0] loop_sec_o
);
   import dscr_pkg::*;

   typedef struct packed {
      logic [7:0] ctl_main;
      logic [7:0] ctl_sec;
      logic [2:0] mode;
      logic [RATIO_W-1:0] rbuf;
      logic [LOOP_W-1:0] loop_main;
      logic [LOOP_W-1:0] loop_sec;
      logic [1:0] load_rs;
      logic [1:0] ref_s1;
      logic [1:0] ref_s2;
      logic [1:0] ref_d;
      logic [1:0] fb_s1;
      logic [1:0] fb_s2;
      logic [1:0] fb_d;
   } dscr_regs_t;

   dscr_regs_t st_r, st_nxt;
   logic rx_done;
   logic [4:0] rx_count;
   logic [SHIFT_W-1:0] rx_data;
   logic [1:0] loop_stby;
   logic [1:0] ref_pulse;
   logic [1:0] fb_pulse;
   logic [1:0] det_en;
   logic [1:0] det_live;
   logic [1:0] ctr_en;
   logic [1:0] det_type;
   logic [1:0] detector_invert_bit;

   // Pulse edge of a synchronised pulse input
   function automatic logic [1:0] rise2(input logic [1:0] now, input logic [1:0] prev);
      rise2 = now & ~prev;
   endfunction : rise2

   dscr_serial_rx u_rx (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .sclk_i(sclk_i),
      .sdin_i(sdin_i),
      .enb_n_i(enb_n_i),
      .done_o(rx_done),
      .count_o(rx_count),
      .data_o(rx_data)
   );

   // Register commit by access length; anything else is dropped
   always_comb begin
      st_nxt = st_r;
      st_nxt.load_rs = 2'b00;
      st_nxt.ref_s1 = {ref_pulse_sec_i, ref_pulse_main_i};
      st_nxt.ref_s2 = st_r.ref_s1;
      st_nxt.ref_d = st_r.ref_s2;
      st_nxt.fb_s1 = {fb_pulse_sec_i, fb_pulse_main_i};
      st_nxt.fb_s2 = st_r.fb_s1;
      st_nxt.fb_d = st_r.fb_s2;
      if (rx_done) begin
         case (rx_count)
            CNT_CTRL: begin
               if (rx_data[C_STEER]) begin
                  st_nxt.ctl_sec = rx_data[7:0];
               end else begin
                  st_nxt.ctl_main = rx_data[7:0];
               end
            end
            CNT_REF: begin
               st_nxt.mode = rx_data[REF_BITS-1:R_MODE_LSB];
               st_nxt.rbuf = rx_data[RATIO_W-1:0];
            end
            CNT_LOOP: begin
               // Register picked by the steer bit of the 24-bit word
               if (rx_data[LOOP_BITS-1]) begin
                  st_nxt.loop_sec = rx_data;
                  st_nxt.load_rs[1] = 1'b1;
               end else begin
                  st_nxt.loop_main = rx_data;
                  st_nxt.load_rs[0] = 1'b1;
               end
            end
            default: st_nxt.load_rs = 2'b00;
         endcase
      end
   end

   // Registers are never cleared by standby, only by reset
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= '{ctl_main: CTRL_RST, ctl_sec: CTRL_RST, mode: MODE_DIV8, rbuf: RATIO_RST,
                   loop_main: '0, loop_sec: '0, load_rs: '0, ref_s1: '0, ref_s2: '0,
                   ref_d: '0, fb_s1: '0, fb_s2: '0, fb_d: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Main standby covers both loops, second only its own
   assign loop_stby[0] = st_r.ctl_main[C_STBY];
   assign loop_stby[1] = st_r.ctl_main[C_STBY] | st_r.ctl_sec[C_STBY];
   assign ref_pulse = rise2(st_r.ref_s2, st_r.ref_d);
   assign fb_pulse = rise2(st_r.fb_s2, st_r.fb_d);
   assign det_type = {st_r.ctl_sec[C_TYPE], st_r.ctl_main[C_TYPE]};
   assign detector_invert_bit = {st_r.ctl_sec[C_POL], st_r.ctl_main[C_POL]};

   // One sequencer per loop
   dscr_loop_seq u_seq_main (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .stby_i(loop_stby[0]),
      .ref_pulse_i(ref_pulse[0]),
      .load_rs_i(st_r.load_rs[0]),
      .ratio_buf_i(st_r.rbuf),
      .counters_en_o(ctr_en[0]),
      .jam_load_o(jam_load_o[0]),
      .det_en_o(det_en[0]),
      .ratio_act_o(ratio_main_o)
   );
   dscr_loop_seq u_seq_sec (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .stby_i(loop_stby[1]),
      .ref_pulse_i(ref_pulse[1]),
      .load_rs_i(st_r.load_rs[1]),
      .ratio_buf_i(st_r.rbuf),
      .counters_en_o(ctr_en[1]),
      .jam_load_o(jam_load_o[1]),
      .det_en_o(det_en[1]),
      .ratio_act_o(ratio_sec_o)
   );

   // Standby effects on the analog controls
   assign stby_o = loop_stby;
   assign counters_en_o = ctr_en & ~loop_stby;
   assign rset_current_en_o = ctr_en & ~loop_stby & ~det_type;
   // Standby gates the detectors at once, not a cycle later via the sequencer
   assign det_live = det_en & ~loop_stby;
   assign prescaler_low_power_o = ~det_live;
   assign charge_float_o = ~det_live | det_type;
   assign current_level_o = {st_r.ctl_sec[C_I2:C_I1], st_r.ctl_main[C_I2:C_I1]};
   assign detector_type_select_o = det_type;
   assign detector_invert_bit_o = detector_invert_bit;

   // Detector stand-in: pulses steer source or sink, polarity flips sense
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         charge_source_o[i] = det_live[i] & ~det_type[i] & (detector_invert_bit[i] ? fb_pulse[i] : ref_pulse[i]);
         charge_sink_o[i] = det_live[i] & ~det_type[i] & (detector_invert_bit[i] ? ref_pulse[i] : fb_pulse[i]);
         // Rest level high; polarity swaps the pair
         phase_ref_n_o[i] = ~(det_live[i] & det_type[i] & (detector_invert_bit[i] ? fb_pulse[i] : ref_pulse[i]));
         phase_fb_n_o[i] = ~(det_live[i] & det_type[i] & (detector_invert_bit[i] ? ref_pulse[i] : fb_pulse[i]));
         // Lock detect is open drain: low in standby, else AND of the pair
         lock_detect_output_o[i] = 1'b0;
         lock_detect_oe_o[i] = loop_stby[i] | ~(phase_ref_n_o[i] & phase_fb_n_o[i]);
      end
   end

   // Port bit from main register only; standby has no say
   assign port_out_o = 1'b0;
   assign port_oe_o = port_select_i & ~st_r.ctl_main[C_PORT];

   // Reference block: mode straight from register; only main standby shuts input
   assign ref_osc_mode_o = st_r.mode;
   assign osc_feedback_off_o = st_r.ctl_main[C_STBY] && (st_r.mode == MODE_STATIC_LOW);
   assign reference_input_inhibit_o = osc_feedback_off_o;
   assign ratio_buf_o = st_r.rbuf;
   assign loop_main_o = st_r.loop_main;
   assign loop_sec_o = st_r.loop_sec;

   a_steer_main: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      rx_done && rx_count == CNT_CTRL && !rx_data[C_STEER] |=> st_r.ctl_main == $past(rx_data[7:0])
      && $stable(st_r.ctl_sec)) else $error("control byte misrouted");
   a_main_stby_both: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      st_r.ctl_main[C_STBY] |-> loop_stby == 2'b11) else $error("main standby incomplete");
   a_stby_det_high: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      loop_stby[1] |-> phase_ref_n_o[1] && phase_fb_n_o[1] && lock_detect_oe_o[1])
      else $error("standby outputs wrong");
   a_ref_keep_ratio: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      rx_done && rx_count == CNT_REF |=> ##1 $stable(ratio_main_o) && $stable(ratio_sec_o))
      else $error("active ratio changed by reference write");
   a_ref_mode_now: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      rx_done && rx_count == CNT_REF |=> ref_osc_mode_o == $past(rx_data[15:13]))
      else $error("mode not applied");
   a_sec_no_osc: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !st_r.ctl_main[C_STBY] |-> !reference_input_inhibit_o) else $error("osc hit by standby");
   a_port_ignores: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      port_select_i |-> port_oe_o == !st_r.ctl_main[C_PORT]) else $error("port bit wrong");
   a_odd_dropped: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      rx_done && rx_count != CNT_CTRL && rx_count != CNT_REF && rx_count != CNT_LOOP
      |=> $stable(st_r.ctl_main) && $stable(st_r.mode)) else $error("odd access stored");
endmodule : dscr_ctrl_regs

// *** tb/dscr_spi_master.sv ***
// Serial master model: the microcontroller side writing framed accesses
`timescale 1ns/1ps
module dscr_spi_master #(
   parameter int HALF = 4
) (
   input wire logic core_clk_i,
   output logic sclk_o,
   output logic sdin_o,
   output logic enb_n_o
);
   // Serial clock idles low outside frames, enable released
   initial begin
      sclk_o = 1'b0;
      sdin_o = 1'b0;
      enb_n_o = 1'b1;
   end

   // One framed access; the bit count and steer bit pick the register, MSB first
   task automatic send(input logic [23:0] word, input int unsigned nbits);
      @(posedge core_clk_i);
      enb_n_o <= 1'b0;
      repeat (HALF) @(posedge core_clk_i);
      for (int i = int'(nbits) - 1; i >= 0; i--) begin
         sdin_o <= word[i];
         repeat (HALF) @(posedge core_clk_i);
         sclk_o <= 1'b1;
         repeat (HALF) @(posedge core_clk_i);
         sclk_o <= 1'b0;
      end
      repeat (HALF) @(posedge core_clk_i);
      enb_n_o <= 1'b1; // Frame end is the only commit point
      sdin_o <= ~sdin_o; // Released data line must not look like held data
      repeat (HALF) @(posedge core_clk_i);
   endtask : send
endmodule : dscr_spi_master

// *** tb/test_dual_synth_control_registers.sv ***
// Self-checking bench for the dual synthesizer control registers
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module test_dual_synth_control_registers;
   import dscr_pkg::*;
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic ref_pulse_main_i = 1'b0;
   logic port_select_i = 1'b1;
   wire logic sclk_i;
   wire logic sdin_i;
   wire logic enb_n_i;
   logic [1:0] stby_o, counters_en_o, jam_load_o, rset_current_en_o, prescaler_low_power_o;
   logic [1:0] charge_float_o, detector_type_select_o, detector_invert_bit_o;
   logic [1:0] phase_ref_n_o, phase_fb_n_o, lock_detect_oe_o;
   logic [3:0] current_level_o;
   logic port_oe_o, osc_feedback_off_o, reference_input_inhibit_o;
   logic [2:0] ref_osc_mode_o;
   logic [RATIO_W-1:0] ratio_buf_o, ratio_main_o, ratio_sec_o;
   logic [LOOP_W-1:0] loop_main_o, loop_sec_o;
   int n_errors = 0;
   int checks = 0;
   int jam_seen;

   // 40 MHz core clock
   initial begin
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   dscr_spi_master spi (.core_clk_i, .sclk_o(sclk_i), .sdin_o(sdin_i), .enb_n_o(enb_n_i));

   dscr_ctrl_regs uut (
      .core_clk_i, .rstn_i, .sclk_i, .sdin_i, .enb_n_i, .ref_pulse_main_i,
      .ref_pulse_sec_i(1'b0), .fb_pulse_main_i(1'b0), .fb_pulse_sec_i(1'b0),
      .port_select_i, .stby_o, .counters_en_o, .jam_load_o, .rset_current_en_o,
      .prescaler_low_power_o, .charge_float_o, .charge_source_o(), .charge_sink_o(),
      .current_level_o, .detector_type_select_o, .detector_invert_bit_o,
      .phase_ref_n_o, .phase_fb_n_o, .lock_detect_output_o(), .lock_detect_oe_o,
      .port_out_o(), .port_oe_o, .ref_osc_mode_o, .osc_feedback_off_o,
      .reference_input_inhibit_o, .ratio_buf_o, .ratio_main_o, .ratio_sec_o,
      .loop_main_o, .loop_sec_o
   );

   task automatic stop_test();
      if (n_errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   // One access, then past the four-cycle commit; sample off the edge
   task automatic wr(input logic [23:0] word, input int unsigned nbits);
      spi.send(word, nbits);
      repeat (2) @(posedge core_clk_i);
      #1;
   endtask : wr

   // Main reference pulse; counts cycles with the jam-load strobe high
   task automatic pulse_ref();
      jam_seen = 0;
      @(posedge core_clk_i);
      ref_pulse_main_i <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         @(posedge core_clk_i);
         if (i == 4) begin
            ref_pulse_main_i <= 1'b0;
         end
         #1;
         if (jam_load_o[0] === 1'b1) begin
            jam_seen++;
         end
      end
   endtask : pulse_ref

   // Hang guard, well beyond the roughly 1200 cycles the sequence needs
   initial begin
      #(30000 * 25);
      n_errors++;
      stop_test();
   end

   initial begin
      repeat (3) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      #1;
      // Power-on defaults
      `CHK("current_level", 4'hF, current_level_o)
      `CHK("type_sel", 2'b00, detector_type_select_o)
      `CHK("invert", 2'b00, detector_invert_bit_o)
      `CHK("osc_mode", MODE_DIV8, ref_osc_mode_o)
      `CHK("port_oe", 1'b0, port_oe_o)
      `CHK("stby", 2'b00, stby_o)
      // Main standby idles both loops, port bit kept released
      wr(24'h00_0072, 8);
      `CHK("stby", 2'b11, stby_o)
      `CHK("float", 2'b11, charge_float_o)
      `CHK("cnt_en", 2'b00, counters_en_o)
      `CHK("rset_en", 2'b00, rset_current_en_o)
      `CHK("presc_lp", 2'b11, prescaler_low_power_o)
      `CHK("phase_ref_n", 2'b11, phase_ref_n_o)
      `CHK("phase_fb_n", 2'b11, phase_fb_n_o)
      `CHK("ld_oe", 2'b11, lock_detect_oe_o)
      pulse_ref();
      `CHK("jam_in_stby", 0, jam_seen)
      // Second register written while in standby
      wr(24'h00_0085, 8);
      `CHK("type_sel", 2'b10, detector_type_select_o)
      `CHK("invert", 2'b10, detector_invert_bit_o)
      `CHK("current_level", 4'h3, current_level_o)
      `CHK("stby", 2'b11, stby_o)
      // Static-low reference with both loops idled from main
      wr({8'h00, MODE_STATIC_LOW, 13'h0123}, 16);
      `CHK("osc_mode", MODE_STATIC_LOW, ref_osc_mode_o)
      `CHK("fb_off", 1'b1, osc_feedback_off_o)
      `CHK("ref_inhibit", 1'b1, reference_input_inhibit_o)
      `CHK("ratio_buf", 13'h0123, ratio_buf_o)
      `CHK("ratio_main", RATIO_RST, ratio_main_o)
      `CHK("current_level", 4'h3, current_level_o)
      // Leave standby, port bit now pulls the port low
      wr(24'h00_0030, 8);
      `CHK("stby", 2'b00, stby_o)
      `CHK("cnt_en", 2'b11, counters_en_o)
      `CHK("rset_en", 2'b01, rset_current_en_o)
      `CHK("fb_off", 1'b0, osc_feedback_off_o)
      `CHK("port_oe", 1'b1, port_oe_o)
      `CHK("ld_oe", 2'b00, lock_detect_oe_o)
      pulse_ref();
      `CHK("jam_pulse", 1, jam_seen)
      // Second-loop standby only; its port bit must not matter
      wr(24'h00_00C7, 8);
      `CHK("stby", 2'b10, stby_o)
      `CHK("fb_off", 1'b0, osc_feedback_off_o)
      `CHK("ref_inhibit", 1'b0, reference_input_inhibit_o)
      `CHK("osc_mode", MODE_STATIC_LOW, ref_osc_mode_o)
      `CHK("port_oe", 1'b1, port_oe_o)
      // Main loop word moves the buffered ratio, swapped at count end
      wr(24'h01_2345, 24);
      `CHK("loop_main", 24'h01_2345, loop_main_o)
      `CHK("loop_sec", 24'h00_0000, loop_sec_o)
      `CHK("ratio_main", RATIO_RST, ratio_main_o)
      pulse_ref();
      `CHK("ratio_main", 13'h0123, ratio_main_o)
      `CHK("ratio_sec", RATIO_RST, ratio_sec_o)
      // Odd bit counts are dropped whole
      for (int k = 0; k < 4; k++) begin
         wr(24'hFF_FFFF, (k == 0) ? 7 : (k == 1) ? 9 : (k == 2) ? 17 : 23);
         `CHK("stby", 2'b10, stby_o)
         `CHK("ratio_buf", 13'h0123, ratio_buf_o)
         `CHK("loop_main", 24'h01_2345, loop_main_o)
         `CHK("current_level", 4'h3, current_level_o)
      end
      stop_test();
   end
endmodule : test_dual_synth_control_registers
